// ---- hw/rbat_bank.sv ----
// One configuration word holding every bit access attribute
`include "rbat_defs.svh"
`default_nettype none
module rbat_bank (
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                hot_rst_i,
	input  wire logic                aux_power_i,
	input  wire logic                strap_i,
	input  wire logic                init_done_i,
	input  wire logic                write_unlock_control_i,
	input  wire rbat_pkg::rbat_acc_t  acc_i,
	input  wire rbat_pkg::rbat_evt_t  evt_i,
	input  wire rbat_pkg::rbat_stat_t stat_i,
	output logic [15:0]              rdata_o,
	output logic                     rvalid_o
);

	logic [1:0]  rst_sync_r;
	logic        rst_n;
	logic [1:0]  hot_sync_r;
	logic        hot_s;
	logic [1:0]  aux_sync_r;
	logic [1:0]  strap_sync_r;
	logic        init_seen_r;
	logic        init_seen_nxt;
	logic        init_pulse;
	logic        init_lock_r;
	logic        init_lock_nxt;
	logic [15:0] main_r;
	logic [15:0] main_nxt;
	logic [1:0]  fr_r;
	logic [1:0]  fr_nxt;
	logic [15:0] evt16;
	logic [15:0] wr_mask;
	logic [15:0] view;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic        qual;
	logic [15:0] d;

	// Reset release through two flops
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hot_sync_r <= 2'h0;
		end else begin
			hot_sync_r <= {hot_sync_r[0], hot_rst_i};
		end
	end
	assign hot_s = hot_sync_r[1];

	// No reset here: the pin level must be known at the release
	always_ff @(posedge core_clk_i) begin
		aux_sync_r   <= {aux_sync_r[0], aux_power_i};
		strap_sync_r <= {strap_sync_r[0], strap_i};
	end

	// Init pulse in the first cycle after release; lock after loading
	always_comb begin
		init_seen_nxt = 1'h1;
		init_lock_nxt = init_lock_r | init_done_i;
	end
	assign init_pulse = ~init_seen_r;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			init_seen_r <= 1'h0;
			init_lock_r <= 1'h0;
		end else begin
			init_seen_r <= init_seen_nxt;
			init_lock_r <= init_lock_nxt;
		end
	end

	assign d    = acc_i.wdata;
	assign qual = d[`RBAT_B_WT];

	always_comb begin
		evt16 = 16'h0000;
		evt16[`RBAT_B_RC]  = evt_i.rc;
		evt16[`RBAT_B_RCW] = evt_i.read_clear_writable_bit;
		evt16[`RBAT_B_W1C] = evt_i.w1c;
		evt16[`RBAT_B_W1CS] = evt_i.w1cs;
	end

	// Writable set per bit; RC, RO, reserved, WT and zero never appear
	always_comb begin
		wr_mask = `RBAT_M_WRALW;
		wr_mask[`RBAT_B_RWL] = write_unlock_control_i;
		wr_mask[`RBAT_B_HWI] = ~init_lock_r;
		wr_mask[`RBAT_B_RW]  = qual;
	end

	always_comb begin
		main_nxt = main_r;
		if (acc_i.rd) begin
			main_nxt = main_nxt & ~`RBAT_M_RDCLR;
		end
		if (acc_i.wr) begin
			main_nxt = (main_nxt & ~wr_mask) | (d & wr_mask);
			main_nxt = main_nxt & ~(d & `RBAT_M_W1C);
		end
		// Set after clear so no event is lost
		main_nxt = main_nxt | evt16;
		main_nxt[`RBAT_B_ROST]  = stat_i.ro_stat;
		main_nxt[`RBAT_B_ROSTK] = stat_i.ros_stat;
		if (init_pulse) begin
			main_nxt[`RBAT_B_HWI] = strap_sync_r[1];
		end
		if (hot_s) begin
			// Hot reset only touches the non-sticky group
			main_nxt = (main_nxt & ~`RBAT_M_HOT) |
			           (`RBAT_RST_VAL & `RBAT_M_HOT);
		end
		main_nxt = main_nxt & `RBAT_M_STORE;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			main_r <= `RBAT_RST_VAL;
		end else begin
			main_r <= main_nxt;
		end
	end

	// Retained pair: bit 0 sticky read-write, bit 1 sticky write-one-clear
	always_comb begin
		fr_nxt = fr_r;
		if (acc_i.wr) begin
			fr_nxt[0] = d[`RBAT_B_RWSFR];
			fr_nxt[1] = fr_r[1] & ~d[`RBAT_B_W1CSFR];
		end
		fr_nxt[1] = fr_nxt[1] | evt_i.w1cs_fr;
		if (init_pulse && !aux_sync_r[1]) begin
			fr_nxt = `RBAT_FR_RST;
		end
	end

	// No async reset: cleared at release only without auxiliary power
	always_ff @(posedge core_clk_i) begin
		fr_r <= fr_nxt;
	end

	always_comb begin
		view = main_r | `RBAT_RO_CONST;
		view[`RBAT_B_RWSFR]  = fr_r[0];
		view[`RBAT_B_W1CSFR] = fr_r[1];
		view = view & `RBAT_M_READ;
	end

	always_comb begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = acc_i.rd;
		if (acc_i.rd) begin
			rdata_nxt = view;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'h0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign rdata_o  = rdata_r;
	assign rvalid_o = rvalid_r;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	rc_read_clear_a: assert property (
		acc_i.rd && !evt_i.rc && !acc_i.wr |=>
		!main_r[`RBAT_B_RC] ##0 rdata_o[`RBAT_B_RC] ==
		$past(main_r[`RBAT_B_RC]))
		else $error("read-clear bit did not clear");

	rc_write_ign_a: assert property (
		acc_i.wr && !acc_i.rd && !evt_i.rc && !hot_s |=>
		main_r[`RBAT_B_RC] == $past(main_r[`RBAT_B_RC]))
		else $error("write changed read-clear bit");

	rcw_write_a: assert property (
		acc_i.wr && !hot_s |=>
		main_r[`RBAT_B_RCW] == ($past(d[`RBAT_B_RCW]) | $past(evt_i.read_clear_writable_bit)))
		else $error("read-clear-writable bit wrong");

	rw_store_a: assert property (
		acc_i.wr && qual && !hot_s |=>
		main_r[`RBAT_B_RW] == $past(d[`RBAT_B_RW]))
		else $error("read-write bit not stored");

	rw_hold_a: assert property (
		!(acc_i.wr && qual) && !hot_s |=> $stable(main_r[`RBAT_B_RW]))
		else $error("read-write bit changed without a write");

	w1c_set_a: assert property (
		evt_i.w1c && !hot_s |=> main_r[`RBAT_B_W1C] [*1])
		else $error("event lost on write-one-clear bit");

	w1c_hold_a: assert property (
		main_r[`RBAT_B_W1C] && !hot_s &&
		!(acc_i.wr && d[`RBAT_B_W1C]) |=> main_r[`RBAT_B_W1C])
		else $error("write-one-clear bit dropped");

	lock_ign_a: assert property (
		acc_i.wr && !write_unlock_control_i |=>
		$stable(main_r[`RBAT_B_RWL]))
		else $error("locked bit was written");

	sticky_hot_a: assert property (
		hot_s && !acc_i.wr && !evt_i.w1cs |=>
		(main_r & `RBAT_M_STICKY) == ($past(main_r) & `RBAT_M_STICKY))
		else $error("hot reset changed sticky bits");

	hw_initialised_bit_lock_a: assert property (
		init_lock_r |=> $stable(main_r[`RBAT_B_HWI]))
		else $error("initialised bit changed after lock");

	fr_keep_a: assert property (
		!acc_i.wr && !evt_i.w1cs_fr && !init_pulse |=> $stable(fr_r))
		else $error("retained bits changed");

	ro_zero_a: assert property (
		rvalid_o |-> rdata_o[`RBAT_B_WT] == 1'h0 &&
		rdata_o[`RBAT_B_ZERO] == 1'h0 && rdata_o[`RBAT_B_ROC] == 1'h1)
		else $error("constant read bits wrong");

	mixed_acc_a: assert property (
		acc_i.wr && d[`RBAT_B_W1C] && qual && !evt_i.w1c && !hot_s |=>
		!main_r[`RBAT_B_W1C] && main_r[`RBAT_B_RW] == $past(d[`RBAT_B_RW]))
		else $error("per-bit attributes not independent");

	set_wins_a: assert property (
		acc_i.wr && d[`RBAT_B_W1CS] && evt_i.w1cs && !hot_s |=>
		main_r[`RBAT_B_W1CS])
		else $error("clear beat hardware set");

	rcw_read_a: assert property (
		acc_i.rd && !acc_i.wr && !evt_i.read_clear_writable_bit |=>
		!main_r[`RBAT_B_RCW])
		else $error("read-clear-writable bit kept after read");

	ro_status_a: assert property (
		acc_i.wr && !hot_s |=>
		main_r[`RBAT_B_ROST] == $past(stat_i.ro_stat))
		else $error("write reached read-only status bit");

	sticky_ro_a: assert property (
		acc_i.wr || hot_s |=>
		main_r[`RBAT_B_ROSTK] == $past(stat_i.ros_stat))
		else $error("sticky read-only bit disturbed");

	w1cs_hold_a: assert property (
		main_r[`RBAT_B_W1CS] && !(acc_i.wr && d[`RBAT_B_W1CS]) |=>
		main_r[`RBAT_B_W1CS])
		else $error("sticky write-one-clear bit dropped");

	fr_set_a: assert property (
		evt_i.w1cs_fr && !init_pulse |=> fr_r[1])
		else $error("event lost on retained write-one-clear bit");

	lock_wr_a: assert property (
		acc_i.wr && write_unlock_control_i |=>
		main_r[`RBAT_B_RWL] == $past(d[`RBAT_B_RWL]))
		else $error("unlocked write did not land");

	hot_group_a: assert property (
		hot_s |=>
		(main_r & `RBAT_M_HOT) == (`RBAT_RST_VAL & `RBAT_M_HOT))
		else $error("hot reset missed a non-sticky bit");

	strap_load_a: assert property (
		init_pulse |=> main_r[`RBAT_B_HWI] == $past(strap_sync_r[1]))
		else $error("initialised bit missed strap value");

	read_hold_a: assert property (
		!acc_i.rd |=> $stable(rdata_o) && !rvalid_o)
		else $error("read data moved without a read");

	read_clear_c: cover property (
		main_r[`RBAT_B_RC] && acc_i.rd ##1 rvalid_o);
	w1c_clear_c: cover property (
		main_r[`RBAT_B_W1C] && acc_i.wr && d[`RBAT_B_W1C]);
	unlock_wr_c: cover property (
		acc_i.wr && write_unlock_control_i);
	hot_rst_c: cover property (hot_s && main_r[`RBAT_B_RWS]);

endmodule : rbat_bank
`default_nettype wire

// ---- inc/rbat_defs.svh ----
// Constants for the per-bit access-attribute register bank
`ifndef RBAT_DEFS_SVH
`define RBAT_DEFS_SVH

`define RBAT_W          16
`define RBAT_B_HWI      0
`define RBAT_B_RC       1
`define RBAT_B_RCW      2
`define RBAT_B_RSV      3
`define RBAT_B_ROC      4
`define RBAT_B_ROST     5
`define RBAT_B_RW       6
`define RBAT_B_W1C      7
`define RBAT_B_RWL      8
`define RBAT_B_ROSTK    9
`define RBAT_B_RWS      10
`define RBAT_B_W1CS     11
`define RBAT_B_RWSFR    12
`define RBAT_B_W1CSFR   13
`define RBAT_B_WT       14
`define RBAT_B_ZERO     15

`define RBAT_M_RDCLR    16'h0006
`define RBAT_M_WRALW    16'h0444
`define RBAT_M_W1C      16'h0880
`define RBAT_M_HOT      16'h00e6
`define RBAT_M_STICKY   16'h0d00
`define RBAT_M_QUAL     16'h0040
`define RBAT_M_STORE    16'h0ff7
`define RBAT_M_READ     16'h3ff7
`define RBAT_RST_VAL    16'h0100
`define RBAT_RO_CONST   16'h0010
`define RBAT_FR_RST     2'h0
`define RBAT_SYNC_W     2

`endif

// ---- inc/rbat_pkg.sv ----
// Types for the per-bit access-attribute register bank
`default_nettype none
package rbat_pkg;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] wdata;
	} rbat_acc_t;

	typedef struct packed {
		logic rc;
		logic read_clear_writable_bit;
		logic w1c;
		logic w1cs;
		logic w1cs_fr;
	} rbat_evt_t;

	typedef struct packed {
		logic ro_stat;
		logic ros_stat;
	} rbat_stat_t;

endpackage : rbat_pkg
`default_nettype wire

// ---- verif/rbat_sw_model.sv ----
// Configuration software model issuing reads and writes
`default_nettype none
module rbat_sw_model (
	input  wire logic                 core_clk_i,
	input  wire logic                 rvalid_i,
	input  wire logic [15:0]          rdata_i,
	output var  rbat_pkg::rbat_acc_t  acc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] last_r;
	initial begin
		acc_o = '0;
		last_r = '0;
	end
	// Entered just after a falling edge; strobe drops at the next one
	task automatic wr(input logic [15:0] d);
		acc_o.wdata = (d & 16'h7ff7) | (last_r & 16'h0008);
		acc_o.wr = 1'b1;
		@(negedge core_clk_i);
		acc_o.wr = 1'b0;
		// Released data must not look like a held value
		acc_o.wdata = ~acc_o.wdata;
	endtask : wr
	task automatic rd(output logic [15:0] d, output logic ok);
		int n;
		acc_o.rd = 1'b1;
		@(negedge core_clk_i);
		acc_o.rd = 1'b0;
		n = 0;
		while (rvalid_i !== 1'b1 && n < 3) begin
			@(negedge core_clk_i);
			n++;
		end
		ok = (rvalid_i === 1'b1);
		d = rdata_i & 16'hfff7;
		last_r = rdata_i;
		// An edge passes so a following read never re-raises the strobe at once
		@(negedge core_clk_i);
	endtask : rd
endmodule : rbat_sw_model
`default_nettype wire

// ---- verif/rbat_bank_tb_top.sv ----
// Self-checking bench for the access-attribute bank
`default_nettype none
module rbat_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 hot_rst = 1'b0;
	logic                 aux = 1'b0;
	logic                 strap = 1'b1;
	logic                 init_done = 1'b0;
	logic                 unlock = 1'b0;
	rbat_pkg::rbat_acc_t  acc;
	rbat_pkg::rbat_evt_t  evt = '0;
	rbat_pkg::rbat_stat_t stat = '0;
	logic [15:0]          rdata;
	logic                 rvalid;
	int                   fails = 0;
	int                   samples_checked = 0;
	always #25 clk = ~clk;
	rbat_bank i_dut (.core_clk_i(clk), .rst_b_i(rst_b),
		.hot_rst_i(hot_rst), .aux_power_i(aux), .strap_i(strap),
		.init_done_i(init_done), .write_unlock_control_i(unlock),
		.acc_i(acc), .evt_i(evt), .stat_i(stat),
		.rdata_o(rdata), .rvalid_o(rvalid));
	rbat_sw_model i_sw (.core_clk_i(clk), .rvalid_i(rvalid),
		.rdata_i(rdata), .acc_o(acc));
	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Reserved bit 3 is masked: its value is not to be relied on
	task automatic rd_chk(input string what, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		i_sw.rd(d, ok);
		if (ok !== 1'b1) begin
			fails++;
			conclude();
		end
		check(what, d, exp & 16'hfff7);
	endtask : rd_chk
	task automatic freset();
		rst_b = 1'b0;
		cyc(16);
		rst_b = 1'b1;
		cyc(6);
	endtask : freset
	task automatic t_reset();
		freset();
		init_done = 1'b1;
		rd_chk("reset word", 16'h0111);
	endtask : t_reset
	task automatic t_events();
		evt = '1;
		cyc(1);
		evt = '0;
		rd_chk("events set", 16'h2997);
		rd_chk("after read", 16'h2991);
	endtask : t_events
	task automatic t_writes();
		i_sw.wr(16'h7fff);
		rd_chk("all ones", 16'h1555);
		rd_chk("rcw cleared", 16'h1551);
	endtask : t_writes
	task automatic t_lock();
		unlock = 1'b1;
		i_sw.wr(16'h0000);
		unlock = 1'b0;
		rd_chk("zeros unlocked", 16'h0051);
	endtask : t_lock
	task automatic t_hot();
		evt.w1c = 1'b1;
		evt.w1cs = 1'b1;
		evt.w1cs_fr = 1'b1;
		cyc(1);
		evt = '0;
		i_sw.wr(16'h5440);
		hot_rst = 1'b1;
		cyc(4);
		hot_rst = 1'b0;
		cyc(3);
		rd_chk("after hot reset", 16'h3c11);
	endtask : t_hot
	// Set and clear in one cycle: the event must not be lost
	task automatic t_race();
		evt.w1c     = 1'b1;
		evt.w1cs    = 1'b1;
		evt.w1cs_fr = 1'b1;
		// Sticky and retained bits rewritten as read, so only clears race
		i_sw.wr(16'h3c80);
		evt = '0;
		rd_chk("set beats clear", 16'h3c91);
	endtask : t_race
	task automatic t_stat();
		stat = '1;
		cyc(3);
		rd_chk("status copy", 16'h3eb1);
		stat = '0;
		cyc(3);
	endtask : t_stat
	task automatic t_aux();
		aux = 1'b1;
		cyc(4);
		freset();
		rd_chk("aux retained", 16'h3111);
		aux = 1'b0;
		cyc(4);
		freset();
		rd_chk("no aux cleared", 16'h0111);
	endtask : t_aux
	initial begin
		t_reset();
		t_events();
		t_writes();
		t_lock();
		t_hot();
		t_race();
		t_stat();
		t_aux();
		conclude();
	end
endmodule : rbat_bank_tb_top
`default_nettype wire
